// file: core/ddc_core.sv
`timescale 1ns/1ps
// Functional notes
// - input buffers off after sixteenth bit
// - select falling edge re-enables input buffers
// - command 1111 targets A, B or both
// - select bits wake, float, 1k, 100k
// - sixteen bits, MSB first, command code select
// - 0000/0001 load input and converter register
// - 0100/0101 load input register only
// - 1000/1001 copy input to converter register
// - 1100 load both channels transparently
// - 1101 load both input registers only
// - 1110 copy both input registers together
// - code is unsigned straight binary
// - data sampled on serial clock falling edge
// - short frame discarded without effect
module ddc_core
  import ddc_pkg::*;
(
  // system
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // serial link
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  // channel outputs
  output logic [ddc_pkg::CODE_W-1:0] channel_a_output,
  output logic [ddc_pkg::CODE_W-1:0] channel_b_output,
  output logic [1:0]                 channel_a_pd_mode,
  output logic [1:0]                 channel_b_pd_mode,
  output logic                       input_buffers_on
);
  import ddc_pkg::*;

  // ==========================================
  // usage limits
  // words under four clk cycles apart merge in the
  // toggle crossing, so the host spaces its frames
  // outputs move four to five clk edges after the
  // sixteenth falling sclk edge of a frame
  // sclk may idle high or low between frames; select
  // high alone clears the bit counter
  // select and din are not re-timed to sclk, which
  // stops between frames; the host keeps their setup
  // a glitch on select ends the frame at once
  // unused commands and power targets change nothing
  // reset clears both converter and input registers
  // and parks both outputs on the weak termination
  // the link counter has no sys_rst of its own: the
  // host raises select once before the first frame

  // ==========================================
  // command decode, shared by both channels
  // code goes into the channel's input register
  function automatic logic stages_a(input logic [3:0] c);
    return (c == CMD_LOAD_A) || (c == CMD_STAGE_A) ||
           (c == CMD_LOAD_AB) || (c == CMD_STAGE_AB);
  endfunction

  // channel b counterpart
  function automatic logic stages_b(input logic [3:0] c);
    return (c == CMD_LOAD_B) || (c == CMD_STAGE_B) ||
           (c == CMD_LOAD_AB) || (c == CMD_STAGE_AB);
  endfunction

  // code goes straight into the converter register
  function automatic logic loads_a(input logic [3:0] c);
    return (c == CMD_LOAD_A) || (c == CMD_LOAD_AB);
  endfunction

  // channel b counterpart
  function automatic logic loads_b(input logic [3:0] c);
    return (c == CMD_LOAD_B) || (c == CMD_LOAD_AB);
  endfunction

  // input register copied into the converter register
  function automatic logic commits_a(input logic [3:0] c);
    return (c == CMD_COMMIT_A) || (c == CMD_COMMIT_AB);
  endfunction

  // channel b counterpart
  function automatic logic commits_b(input logic [3:0] c);
    return (c == CMD_COMMIT_B) || (c == CMD_COMMIT_AB);
  endfunction

  // power command target covers the channel
  function automatic logic pd_hits_a(input logic [2:0] tgt);
    return (tgt == PD_TGT_A) || (tgt == PD_TGT_AB);
  endfunction

  // channel b counterpart
  function automatic logic pd_hits_b(input logic [2:0] tgt);
    return (tgt == PD_TGT_B) || (tgt == PD_TGT_AB);
  endfunction

  // ==========================================
  // link domain: shift register on sclk falling edge
  logic [FRAME_BITS-1:0] shift_q;
  logic [CNT_W-1:0]      bit_cnt_q;
  logic [FRAME_BITS-1:0] word_q;
  logic                  word_tgl_q;
  logic                  frame_done_q;

  // count only; select high clears, a fresh frame starts at zero
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != LAST_BIT_CNT) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // data shift, msb first
  always_ff @(negedge sclk) begin
    if (!cs_n && bit_cnt_q != LAST_BIT_CNT) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], din};
    end
  end

  // capture complete word and flag it by toggle
  always_ff @(negedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_q     <= '0;
      word_tgl_q <= 1'b0;
    end else if (!cs_n && bit_cnt_q == LAST_BIT_CNT - 5'h01) begin
      word_q     <= {shift_q[FRAME_BITS-2:0], din};
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // sixteen bits in: buffers gated until select falls again
  // registered here so that no multi-bit counter value
  // is ever sampled across the crossing
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      frame_done_q <= 1'b0;
    end else if (bit_cnt_q == LAST_BIT_CNT - 5'h01) begin
      frame_done_q <= 1'b1;
    end
  end

  // ==========================================
  // crossing into clk domain
  // three things cross from the link: the word toggle,
  // the select level and the sixteen-bit done level;
  // each is a single bit that changes at most twice per
  // frame, so a plain two-flop synchroniser is enough
  // the word itself never crosses bit by bit: it is
  // captured only after its toggle has been seen
  // select is sampled here, never the link counter
  logic [2:0] tgl_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] done_sync_q;
  logic       new_word;
  logic       done_flag;

  // two flops per bit, a third toggle flop for the edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_sync_q  <= '0;
      cs_sync_q   <= 2'h3; // select idles high
      done_sync_q <= '0;
    end else begin
      tgl_sync_q  <= {tgl_sync_q[1:0], word_tgl_q};
      cs_sync_q   <= {cs_sync_q[0], cs_n};
      done_sync_q <= {done_sync_q[0], frame_done_q};
    end
  end

  assign done_flag = done_sync_q[1];

  // ==========================================
  // command capture into the clk domain
  // word_q stands still for fifteen link cycles after
  // its toggle, far longer than the crossing takes
  // apply_q gives the fields one cycle to settle
  // before any register reads them
  logic              word_seen;
  logic [3:0]        cmd_q;
  logic [CODE_W-1:0] code_q;
  logic [1:0]        sel_q;
  logic              apply_q;

  assign word_seen = tgl_sync_q[2] ^ tgl_sync_q[1];

  // latch the fields once, then apply them a cycle later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q   <= '0;
      code_q  <= CODE_RESET;
      sel_q   <= '0;
      apply_q <= 1'b0;
    end else begin
      apply_q <= word_seen;
      if (word_seen) begin
        cmd_q  <= word_q[CMD_MSB:CMD_LSB];
        code_q <= word_q[CODE_MSB:CODE_LSB];
        sel_q  <= word_q[SEL_MSB:SEL_LSB];
      end
    end
  end

  // fields seen by the register processes
  // cmd holds the last command; new_word says when
  logic [3:0]        cmd;
  logic [CODE_W-1:0] code;
  logic [1:0]        sel;
  assign new_word = apply_q;
  assign cmd      = cmd_q;
  assign code     = code_q;
  assign sel      = sel_q;

  // ==========================================
  // input buffer gating status
  // registered level; it follows select and the done
  // level three to four clk edges late
  // gating itself happens at the pads
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_buffers_on <= 1'b0;
    end else if (!cs_sync_q[1] && !done_flag) begin
      input_buffers_on <= 1'b1;
    end else begin
      input_buffers_on <= 1'b0;
    end
  end

  // ==========================================
  // input registers, one process per channel
  // staged codes wait here until a commit copies them;
  // a later stage or a transparent load overwrites them
  logic [CODE_W-1:0] in_a_q;
  logic [CODE_W-1:0] in_b_q;

  // channel a input register; commits leave it alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_a_q <= CODE_RESET;
    end else if (new_word && stages_a(cmd)) begin
      in_a_q <= code;
    end
  end

  // channel b input register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_b_q <= CODE_RESET;
    end else if (new_word && stages_b(cmd)) begin
      in_b_q <= code;
    end
  end

  // ==========================================
  // converter registers drive the outputs
  // both channels see the same strobe, so a joint
  // commit or load lands on one clk edge
  // channel a: code loaded straight, or input copied
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_a_output <= CODE_RESET;
    end else if (new_word && loads_a(cmd)) begin
      channel_a_output <= code;
    end else if (new_word && commits_a(cmd)) begin
      channel_a_output <= in_a_q;
    end
  end

  // channel b converter register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_b_output <= CODE_RESET;
    end else if (new_word && loads_b(cmd)) begin
      channel_b_output <= code;
    end else if (new_word && commits_b(cmd)) begin
      channel_b_output <= in_b_q;
    end
  end

  // ==========================================
  // power-down modes, held until the next power command that targets the channel
  // register contents are untouched while powered down
  // a wake-up needs settling time before new codes;
  // that wait is the host's, nothing here delays
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_a_pd_mode <= PD_RESET;
    end else if (new_word && cmd == CMD_POWER && pd_hits_a(code[2:0])) begin
      channel_a_pd_mode <= sel;
    end
  end

  // channel b power-down mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_b_pd_mode <= PD_RESET;
    end else if (new_word && cmd == CMD_POWER && pd_hits_b(code[2:0])) begin
      channel_b_pd_mode <= sel;
    end
  end

endmodule

// file: core/ddc_pkg.sv
package ddc_pkg;
  // ==========================================
  // frame layout
  localparam int FRAME_BITS   = 16;
  localparam int CMD_MSB      = 15;
  localparam int CMD_LSB      = 12;
  localparam int CODE_MSB     = 11;
  localparam int CODE_LSB     = 2;
  localparam int SEL_MSB      = 1;
  localparam int SEL_LSB      = 0;
  localparam int CODE_W       = 10;
  localparam int CNT_W        = 5;
  localparam logic [4:0] LAST_BIT_CNT = 5'h10;

  // ==========================================
  // command codes
  localparam logic [3:0] CMD_LOAD_A     = 4'h0;
  localparam logic [3:0] CMD_LOAD_B     = 4'h1;
  localparam logic [3:0] CMD_STAGE_A    = 4'h4;
  localparam logic [3:0] CMD_STAGE_B    = 4'h5;
  localparam logic [3:0] CMD_COMMIT_A   = 4'h8;
  localparam logic [3:0] CMD_COMMIT_B   = 4'h9;
  localparam logic [3:0] CMD_LOAD_AB    = 4'hc;
  localparam logic [3:0] CMD_STAGE_AB   = 4'hd;
  localparam logic [3:0] CMD_COMMIT_AB  = 4'he;
  localparam logic [3:0] CMD_POWER      = 4'hf;

  // ==========================================
  // power-down target in code bits 2..0
  localparam logic [2:0] PD_TGT_A  = 3'h0;
  localparam logic [2:0] PD_TGT_B  = 3'h1;
  localparam logic [2:0] PD_TGT_AB = 3'h4;

  // ==========================================
  // output modes and reset values
  localparam logic [1:0] PD_ACTIVE  = 2'h0;
  localparam logic [1:0] PD_FLOAT   = 2'h1;
  localparam logic [1:0] PD_1K      = 2'h2;
  localparam logic [1:0] PD_100K    = 2'h3;
  localparam logic [1:0] PD_RESET   = PD_100K;
  localparam logic [9:0] CODE_RESET = 10'h000;
endpackage

// file: tb/ddc_assertions.sv
`timescale 1ns/1ps
// ==========
// checker on the core ports
module ddc_assertions
  import ddc_pkg::*;
(
  // system and link
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              cs_n,
  // outputs
  input wire logic [CODE_W-1:0] channel_a_output,
  input wire logic [CODE_W-1:0] channel_b_output,
  input wire logic [1:0]        channel_a_pd_mode,
  input wire logic [1:0]        channel_b_pd_mode,
  input wire logic              input_buffers_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // link idle for eight cycles
  sequence s_idle; cs_n [*8]; endsequence
  property p_rst_a; $fell(sys_rst) |-> channel_a_output == 0 && channel_a_pd_mode == 3; endproperty
  property p_rst_b; $fell(sys_rst) |-> channel_b_output == 0 && channel_b_pd_mode == 3; endproperty
  property p_on; $fell(cs_n) |-> ##[1:6] input_buffers_on; endproperty
  property p_off; $rose(cs_n) |-> ##[0:5] !input_buffers_on; endproperty
  property p_ha; s_idle |=> $stable(channel_a_output); endproperty
  property p_hb; s_idle |=> $stable(channel_b_output); endproperty
  property p_pa; s_idle |=> $stable(channel_a_pd_mode); endproperty
  property p_pb; s_idle |=> $stable(channel_b_pd_mode); endproperty
  a_rst_a: assert property (p_rst_a) else $error("reset state a");
  a_rst_b: assert property (p_rst_b) else $error("reset state b");
  a_on: assert property (p_on) else $error("buffers not on");
  a_off: assert property (p_off) else $error("buffers not off");
  a_ha: assert property (p_ha) else $error("a moved idle");
  a_hb: assert property (p_hb) else $error("b moved idle");
  a_pa: assert property (p_pa) else $error("pd a moved idle");
  a_pb: assert property (p_pb) else $error("pd b moved idle");
  c_frame: cover property ($fell(cs_n));
  c_load: cover property ($changed(channel_a_output));
  c_pd: cover property (channel_b_pd_mode == PD_1K);
endmodule
bind ddc_core ddc_assertions i_chk (.clk, .sys_rst, .cs_n, .channel_a_output,
  .channel_b_output, .channel_a_pd_mode, .channel_b_pd_mode, .input_buffers_on);

// file: tb/ddc_core_test.sv
`timescale 1ns/1ps
// ==========
// bench top
module ddc_core_test;
  import ddc_pkg::*;
  logic clk, sys_rst, sclk, cs_n, din, bon;
  logic [9:0] oa, ob;
  logic [1:0] pa, pb;
  int n_mismatch = 0;
  int num_checks = 0;
  ddc_core i_dut (.clk, .sys_rst, .sclk, .cs_n, .din, .channel_a_output(oa),
    .channel_b_output(ob), .channel_a_pd_mode(pa), .channel_b_pd_mode(pb),
    .input_buffers_on(bon));
  ddc_host host (.sclk, .cs_n, .din);
  // system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tx(input logic [3:0] c, input logic [9:0] d, input logic [1:0] s);
    host.send({c, d, s}, 16, 10);
  endtask
  // command sequence
  initial begin
    sys_rst = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    chk({8'h0, pb}, 10'h3);
    repeat (3) @(negedge clk);
    tx(CMD_POWER, 10'h3fc, PD_ACTIVE);
    #8000;
    chk({8'h0, pa}, 10'h0);
    tx(CMD_LOAD_A, 10'h3ff, 2'h3);
    chk(oa, 10'h3ff);
    tx(CMD_STAGE_B, 10'h155, 2'h0);
    chk(ob, 10'h000);
    tx(CMD_COMMIT_B, 10'h2aa, 2'h0);
    chk(ob, 10'h155);
    tx(CMD_LOAD_AB, 10'h200, 2'h0);
    chk(oa, 10'h200);
    tx(CMD_STAGE_AB, 10'h0f0, 2'h0);
    chk(ob, 10'h200);
    tx(CMD_COMMIT_AB, 10'h3c3, 2'h0);
    chk(oa, 10'h0f0);
    host.send({CMD_LOAD_A, 10'h001, 2'h0}, 15, 10);
    chk(oa, 10'h0f0);
    fork
      host.send({CMD_LOAD_B, 10'h011, 2'h0}, 20, 500);
      begin
        #400 chk({9'h0, bon}, 10'h1);
        #700 chk({9'h0, bon}, 10'h0);
      end
    join
    chk(ob, 10'h011);
    for (int m = 1; m < 4; m++) begin
      tx(CMD_POWER, 10'h000, m[1:0]);
      chk({8'h0, pa}, m[9:0]);
    end
    tx(CMD_POWER, 10'h001, PD_1K);
    chk({8'h0, pb}, 10'h2);
    chk(ob, 10'h011);
    tx(CMD_STAGE_A, 10'h123, 2'h0);
    chk(oa, 10'h0f0);
    tx(CMD_COMMIT_A, 10'h000, 2'h0);
    chk(oa, 10'h123);
    tx(4'h2, 10'h3ff, 2'h0);
    chk(oa, 10'h123);
    tx(CMD_POWER, 10'h002, PD_ACTIVE);
    chk({8'h0, pb}, 10'h2);
    chk({8'h0, pa}, 10'h3);
    conclude();
  end
endmodule

// file: tb/ddc_host.sv
`timescale 1ns/1ps
// ==========
// serial host model
module ddc_host (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic din
);
  // idle link
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // one frame, clock still outside it
  task automatic send(input logic [15:0] w, input int nb, input int hold);
    cs_n = 1'b0;
    #30;
    for (int i = 0; i < nb; i++) begin
      din = (i < 16) ? w[15-i] : ~din;
      sclk = 1'b1;
      #24;
      sclk = 1'b0;
      #24;
    end
    #(hold);
    cs_n = 1'b1;
    din = ~din;
    #400;
  endtask
endmodule
